// >>> rtl/power_ctl_defines.vh
`ifndef POWER_CTL_DEFINES_VH
`define POWER_CTL_DEFINES_VH

// Field positions within the first low control register of the calendar unit.
`define POWER_ENABLE_BIT    10
`define POWER_POLARITY_BIT  9

// Output select code that routes the power switch signal to the calendar pin.
`define PIN_SEL_POWER_CTL   3'h3
`define PIN_SEL_WIDTH       3

// Default window lengths, in timebase ticks.
`define STAB_TICKS_DEFAULT  16'h0004
`define SAMPLE_TICKS_DEFAULT 16'h0004
`define WINDOW_WIDTH        16

// Sequencer states.
`define ST_IDLE             2'h0
`define ST_STABLE           2'h1
`define ST_SAMPLE           2'h2

`endif

// >>> rtl/window_timer.v
`timescale 1ns/1ps
`include "power_ctl_defines.vh"

// Loadable down-counter that flags expiry after a programmed number of ticks.
module window_timer #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             load,
  input  wire [WIDTH-1:0] length,
  input  wire             tick,
  output wire             expired
);

  reg [WIDTH-1:0] count;
  reg             running;

  // A zero length still lasts one tick so a window never vanishes entirely.
  always @(posedge clk) begin
    if (!resetn) begin
      count   <= {WIDTH{1'b0}};
      running <= 1'b0;
    end else if (load) begin
      count   <= (length == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1} : length;
      running <= 1'b1;
    end else if (running && tick) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      if (count == {{(WIDTH-1){1'b0}}, 1'b1})
        running <= 1'b0;
    end
  end

  // Expiry is a single pulse on the tick that empties the counter.
  assign expired = running && tick && (count == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

// >>> rtl/pin_mux.v
`timescale 1ns/1ps
`include "power_ctl_defines.vh"

// Drives the calendar pin from the power switch signal when selected.
module pin_mux (
  input  wire       clk,
  input  wire       resetn,
  input  wire       pin_enable,
  input  wire [2:0] pin_select,
  input  wire       power_level,
  output reg        pin_out,
  output reg        pin_oe
);

  // Registered so the pin never glitches while the select field changes.
  always @(posedge clk) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_oe  <= pin_enable && (pin_select == `PIN_SEL_POWER_CTL);
      pin_out <= pin_enable && (pin_select == `PIN_SEL_POWER_CTL) && power_level;
    end
  end

endmodule

// >>> rtl/periodic_power_ctl.v
// Notes on behaviour
// - Autonomously power up, settle, sample, then power down the peripheral, periodically.
// - The sequencer runs only while the calendar unit's module enable is 1; the pin routing runs regardless.
// - Enable bit 10 of control register one switches power control on or off.
// - Pin carries the switch signal only with pin enable 1 and select 011.
// - Bit 9 of control register one selects active-high or active-low output.
// - The repeat enable lets a periodic repeat event that arrives while idle start a new cycle.
// - When enabled and running, drive a power output and a sample gate.
// - The stability window starts when the power output is asserted.
// - After stability, the sample gate is asserted for the sample window.
// - At sample window expiry, gate and power both drop, powering down.
`timescale 1ns/1ps
`include "power_ctl_defines.vh"

module periodic_power_ctl #(
  parameter WIDTH = `WINDOW_WIDTH
) (
  // Clock and reset.
  input  wire             MCLK,
  input  wire             RESETN,
  // Calendar unit timebase.
  input  wire             TIMEBASE_TICK,
  input  wire             REPEAT_EVENT,
  // Configuration bits.
  input  wire             CALENDAR_MODULE_ENABLE,
  input  wire [15:0]      CALENDAR_CONTROL1_LOW,
  input  wire             PERIODIC_REPEAT_ENABLE,
  input  wire             CALENDAR_PIN_OUTPUT_ENABLE,
  input  wire [2:0]       CALENDAR_PIN_OUTPUT_SELECT,
  input  wire [WIDTH-1:0] STABILITY_TICKS,
  input  wire [WIDTH-1:0] SAMPLE_TICKS,
  // Outputs.
  output reg              EXTERNAL_POWER_SWITCH_SIGNAL,
  output reg              SAMPLE_GATE,
  output wire             CALENDAR_PIN_OUT,
  output wire             CALENDAR_PIN_OE,
  output wire [1:0]       SEQUENCE_STATE
);

  reg  [1:0] state;
  reg  [1:0] next_state;
  wire       active;
  wire       polarity;
  wire       start;
  wire       stab_done;
  wire       sample_done;

  // The sequencer is qualified by the module enable and its own enable; the pin routing is not.
  assign active   = CALENDAR_MODULE_ENABLE && CALENDAR_CONTROL1_LOW[`POWER_ENABLE_BIT];
  assign polarity = CALENDAR_CONTROL1_LOW[`POWER_POLARITY_BIT];
  // A cycle only begins on a repeat event with repetition enabled.
  assign start    = active && PERIODIC_REPEAT_ENABLE && REPEAT_EVENT
                    && (state == `ST_IDLE);

  // Next-state logic; dropping the enable aborts at once so power is removed.
  always @* begin
    next_state = state;
    if (!active) begin
      next_state = `ST_IDLE;
    end else begin
      case (state)
        `ST_IDLE: begin
          if (start)
            next_state = `ST_STABLE;
        end
        `ST_STABLE: begin
          if (stab_done)
            next_state = `ST_SAMPLE;
        end
        `ST_SAMPLE: begin
          if (sample_done)
            next_state = `ST_IDLE;
        end
        default: begin
          next_state = `ST_IDLE;
        end
      endcase
    end
  end

  // State register and registered outputs.
  // Reset parks the power output at its idle level, so that an active-low
  // switch is not pulsed on through the pin in the cycle after release.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      state                        <= `ST_IDLE;
      SAMPLE_GATE                  <= 1'b0;
      EXTERNAL_POWER_SWITCH_SIGNAL <= polarity;
    end else begin
      state       <= next_state;
      SAMPLE_GATE <= (next_state == `ST_SAMPLE);
      // Inactive level follows the polarity so the peripheral stays unpowered.
      EXTERNAL_POWER_SWITCH_SIGNAL <= (next_state != `ST_IDLE) ^ polarity;
    end
  end

  // Stability window timer, loaded as power is asserted.
  window_timer #(
    .WIDTH (WIDTH)
  ) stab_timer (
    .clk     (MCLK),
    .resetn  (RESETN && active),
    .load    (start),
    .length  (STABILITY_TICKS),
    .tick    (TIMEBASE_TICK),
    .expired (stab_done)
  );

  // Sample window timer, loaded when the stability window closes.
  window_timer #(
    .WIDTH (WIDTH)
  ) sample_timer (
    .clk     (MCLK),
    .resetn  (RESETN && active),
    .load    (stab_done && (state == `ST_STABLE)),
    .length  (SAMPLE_TICKS),
    .tick    (TIMEBASE_TICK),
    .expired (sample_done)
  );

  // Pin routing; the level already carries the chosen polarity.
  pin_mux pin (
    .clk         (MCLK),
    .resetn      (RESETN),
    .pin_enable  (CALENDAR_PIN_OUTPUT_ENABLE),
    .pin_select  (CALENDAR_PIN_OUTPUT_SELECT),
    .power_level (EXTERNAL_POWER_SWITCH_SIGNAL),
    .pin_out     (CALENDAR_PIN_OUT),
    .pin_oe      (CALENDAR_PIN_OE)
  );

  assign SEQUENCE_STATE = state;

endmodule

// >>> bench/power_ctl_checker.sv
`timescale 1ns/1ps
module power_ctl_checker (
  // Clock and reset.
  input wire        MCLK,
  input wire        RESETN,
  // Timebase strobes.
  input wire        TIMEBASE_TICK,
  input wire        REPEAT_EVENT,
  // Configuration.
  input wire        CALENDAR_MODULE_ENABLE,
  input wire [15:0] CALENDAR_CONTROL1_LOW,
  input wire        PERIODIC_REPEAT_ENABLE,
  input wire        CALENDAR_PIN_OUTPUT_ENABLE,
  input wire [2:0]  CALENDAR_PIN_OUTPUT_SELECT,
  // Watched outputs of the sequencer.
  input wire        EXTERNAL_POWER_SWITCH_SIGNAL,
  input wire        SAMPLE_GATE,
  input wire        CALENDAR_PIN_OUT,
  input wire        CALENDAR_PIN_OE,
  input wire [1:0]  SEQUENCE_STATE
);
  // Short views of the causes.
  wire       run = CALENDAR_MODULE_ENABLE && CALENDAR_CONTROL1_LOW[10];
  wire       sel = CALENDAR_PIN_OUTPUT_ENABLE && CALENDAR_PIN_OUTPUT_SELECT == 3'h3;
  wire       pw  = EXTERNAL_POWER_SWITCH_SIGNAL;
  wire       pol = CALENDAR_CONTROL1_LOW[9];
  wire [1:0] s   = SEQUENCE_STATE;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  AST_START: assert property (s == 2'h0 && run && REPEAT_EVENT && PERIODIC_REPEAT_ENABLE |=> s == 2'h1)
    else $error("no start");
  AST_OFF: assert property (!run |=> s == 2'h0 && !SAMPLE_GATE)
    else $error("not stopped");
  AST_OE: assert property ($past(RESETN) |-> CALENDAR_PIN_OE == $past(sel))
    else $error("pin enable");
  AST_PIN: assert property ($past(RESETN) |-> CALENDAR_PIN_OUT == ($past(sel) && $past(pw)))
    else $error("pin level");
  AST_ON: assert property (s != 2'h0 |-> pw == !pol)
    else $error("power not on");
  AST_IDLE: assert property ($past(RESETN) && s == 2'h0 |-> pw == pol)
    else $error("power not off");
  AST_GATE: assert property (SAMPLE_GATE == (s == 2'h2))
    else $error("gate");
  AST_HOLD: assert property (s == 2'h1 && !TIMEBASE_TICK |=> s != 2'h2)
    else $error("early sample");
  cover property (s == 2'h1 ##1 s == 2'h2);
  cover property (s == 2'h2 ##1 s == 2'h0);
  cover property (s != 2'h0 && !run);
endmodule
bind periodic_power_ctl power_ctl_checker power_ctl_checker_i (
  .MCLK                         (MCLK),
  .RESETN                       (RESETN),
  .TIMEBASE_TICK                (TIMEBASE_TICK),
  .REPEAT_EVENT                 (REPEAT_EVENT),
  .CALENDAR_MODULE_ENABLE       (CALENDAR_MODULE_ENABLE),
  .CALENDAR_CONTROL1_LOW        (CALENDAR_CONTROL1_LOW),
  .PERIODIC_REPEAT_ENABLE       (PERIODIC_REPEAT_ENABLE),
  .CALENDAR_PIN_OUTPUT_ENABLE   (CALENDAR_PIN_OUTPUT_ENABLE),
  .CALENDAR_PIN_OUTPUT_SELECT   (CALENDAR_PIN_OUTPUT_SELECT),
  .EXTERNAL_POWER_SWITCH_SIGNAL (EXTERNAL_POWER_SWITCH_SIGNAL),
  .SAMPLE_GATE                  (SAMPLE_GATE),
  .CALENDAR_PIN_OUT             (CALENDAR_PIN_OUT),
  .CALENDAR_PIN_OE              (CALENDAR_PIN_OE),
  .SEQUENCE_STATE               (SEQUENCE_STATE)
);

// >>> bench/ext_device.sv
`timescale 1ns/1ps
// Switched peripheral; trusts its supply only after it has settled.
module ext_device #(
  parameter SETTLE = 3
) (
  // Clock of the sampling logic.
  input  wire mclk,
  // Switched supply as it arrives from the calendar pin.
  input  wire pin,
  input  wire pin_oe,
  input  wire active_low,
  // High once the supply has stood for the settling time.
  output reg  stable
);
  integer up = 0;
  // Any loss of supply restarts the settling count; an unknown pin counts as no supply.
  always @(posedge mclk) begin
    up = (pin_oe === 1'b1 && (pin ^ active_low) === 1'b1) ? up + 1 : 0;
    stable <= up >= SETTLE;
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  reg        mclk = 1'h0, resetn = 1'h0, tk = 1'h0, rp = 1'h0, uen = 1'h0, rpe = 1'h0;
  reg        pe = 1'h0, mp = 1'h0, mpo = 1'h0, moe = 1'h0;
  reg [15:0] ctl = 16'h0000, stb = 16'h0000, smp = 16'h0000;
  reg [2:0]  sel = 3'h0;
  reg [31:0] rnd = 32'h1183;
  wire       pw, gt, po, poe, dev_ok;
  wire [1:0] st;
  integer    fails = 0, num_checks = 0, ms = 0, n = 0, mup = 0, c, ph;
  periodic_power_ctl periodic_power_ctl_i (.MCLK(mclk), .RESETN(resetn), .TIMEBASE_TICK(tk),
    .REPEAT_EVENT(rp), .CALENDAR_MODULE_ENABLE(uen), .CALENDAR_CONTROL1_LOW(ctl),
    .PERIODIC_REPEAT_ENABLE(rpe), .CALENDAR_PIN_OUTPUT_ENABLE(pe),
    .CALENDAR_PIN_OUTPUT_SELECT(sel), .STABILITY_TICKS(stb), .SAMPLE_TICKS(smp),
    .EXTERNAL_POWER_SWITCH_SIGNAL(pw), .SAMPLE_GATE(gt), .CALENDAR_PIN_OUT(po),
    .CALENDAR_PIN_OE(poe), .SEQUENCE_STATE(st));
  ext_device ext_device_i (.mclk(mclk), .pin(po), .pin_oe(poe), .active_low(ctl[9]),
    .stable(dev_ok));
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [47:0] nm, input [1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("%0d checks, %0d mismatches", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always #5 mclk = ~mclk;
  // Reference sequencer; the pin takes the power level from before this edge.
  always @(posedge mclk) begin
    mup = (moe && (mpo ^ ctl[9])) ? mup + 1 : 0; // Cycles the pin has powered the device.
    moe = resetn && pe && sel == 3'h3;
    mpo = moe && mp;
    c = ms == 1 ? stb : smp;
    if (!resetn || !(uen && ctl[10])) ms = 0;
    else if (ms == 0) begin
      n = 0;
      if (rp && rpe) ms = 1;
    end else if (tk) begin
      n = n + 1;
      if (n >= c) begin
        ms = (ms + 1) % 3;
        n = 0;
      end
    end
    mp = ms != 0 ? !ctl[9] : ctl[9];
  end
  // Compare every cycle, then drive fresh random strobes.
  always @(negedge mclk) begin
    chk("state", st, ms[1:0]);
    chk("gate", {1'h0, gt}, {1'h0, ms == 2});
    chk("power", {1'h0, pw}, {1'h0, mp});
    chk("pin", {poe, po}, {moe, mpo});
    chk("device", {1'h0, dev_ok}, {1'h0, mup >= 3});
    rnd = xs(rnd);
    tk = rnd[0] & rnd[1];
    rp = rnd[2] & rnd[3] & rnd[4];
    if (resetn && ph == 5 && rnd[5:0] == 6'h00) uen = ~uen;
  end
  // Runs: plain, unit off, power off, repeat off, pin off, aborts; each starts in reset.
  initial begin
    for (ph = 0; ph < 6; ph = ph + 1) begin
      resetn <= 1'h0;
      repeat (5) @(negedge mclk);
      uen <= ph != 1;
      ctl <= {5'h00, ph != 2, ph[0], rnd[8:0]};
      rpe <= ph != 3;
      pe <= ph != 4;
      sel <= ph > 3 ? rnd[18:16] : 3'h3;
      stb <= ph[15:0] << 1;
      smp <= 16'h0005 - ph[15:0];
      resetn <= 1'h1;
      repeat (400) @(negedge mclk);
      $display("test %0d done", ph);
    end
    complete_run;
  end
  // A hang past twice the expected run time ends it as a mismatch.
  initial begin
    #50000;
    fails++;
    complete_run;
  end
endmodule
